// ### hw/smc_pkg.sv
package smc_pkg;

  // ----------------------------------------------------------------
  // standby selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_STOP = 2'h1;
  localparam logic [1:0] SEL_SLEEP = 2'h2;
  localparam logic [1:0] SEL_IDLE = 2'h3;
  // code 0 also selects the halt form of idle
  localparam logic [1:0] SEL_IDLE_ALT = 2'h0;

  // ----------------------------------------------------------------
  // status register field position and widths
  // ----------------------------------------------------------------
  localparam int MASK_LSB = 13;
  localparam int MASK_MSB = 15;
  localparam int PRIO_W = 3;
  localparam int PERIPH_N = 5;

  // peripheral gate indices
  localparam int PG_TIMER = 0;
  localparam int PG_SERIAL = 1;
  localparam int PG_BUSSER = 2;
  localparam int PG_CONV = 3;
  localparam int PG_WDOG = 4;

  // ----------------------------------------------------------------
  // warm-up counts in low-speed clock ticks, indexed by select code
  // ----------------------------------------------------------------
  localparam logic [16:0] WUP_CNT_0 = 17'h00001;
  localparam logic [16:0] WUP_CNT_1 = 17'h00100;
  localparam logic [16:0] WUP_CNT_2 = 17'h04000;
  localparam logic [16:0] WUP_CNT_3 = 17'h10000;

  // low-speed tick divider: 40 MHz down to roughly 32 kHz
  localparam int MCLK_HZ = 40000000;
  localparam int LS_HZ = 32768;
  localparam int LS_DIV = MCLK_HZ / LS_HZ;

  typedef enum logic [2:0] {
    SM_NORMAL = 3'b000,
    SM_SLOW = 3'b001,
    SM_HALT = 3'b010,
    SM_DOZE = 3'b011,
    SM_SLEEP = 3'b100,
    SM_STOP = 3'b101,
    SM_WARMUP = 3'b110,
    SM_ARM = 3'b111
  } smc_state_t;

endpackage : smc_pkg

// ### hw/smc_tick_div.sv
`timescale 1ns/100ps
module smc_tick_div
  import smc_pkg::*;
#(
  parameter int DIV = LS_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);

  logic [15:0] cnt;

  // free divider; held cleared while stopped so restart is clean
  always_ff @(posedge mclk) begin
    if (!rst_n || !run) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule : smc_tick_div

// ### hw/smc_warmup.sv
`timescale 1ns/100ps
module smc_warmup
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  input wire logic [1:0] warmup_time_select,
  output logic done
);

  logic [16:0] remain;
  logic busy;

  function automatic logic [16:0] wup_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: wup_len = WUP_CNT_0;
      2'h1: wup_len = WUP_CNT_1;
      2'h2: wup_len = WUP_CNT_2;
      2'h3: wup_len = WUP_CNT_3;
    endcase
  endfunction : wup_len

  // counts low-speed ticks; done is a one-cycle pulse
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      remain <= 17'h00000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= wup_len(warmup_time_select);
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (remain == 17'h00001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain <= remain - 17'h00001;
      end
    end
  end

endmodule : smc_warmup

// ### hw/smc_standby_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - halt request enters mode chosen by selection
// - doze request always enters doze idle
// - idle stops cpu; peripherals follow idle-enables
// - halt idle freezes core, ignores bus requests
// - doze idle freezes core, grants bus requests
// - dma stopped in halt, runs in doze
// - ports off in halt; irq ctrl, bus on
// - sleep runs only low-speed osc and rtc
// - rtc clocked in idle and sleep
// - stop switches off every oscillator and clock
// - pll on in normal/idle unless slowActive; ext clock osc off
// - slow clocks cpu, irq ctrl, bus, ports, wdt, rtc
// - leave standby only on interrupt or reset
// - wake eligibility from mode and source, not mask level
// - priority above mask: service, then next instruction
// - priority at or below mask: retry, stay pending
// - nmi wake always serviced
// - stop wake runs warm-up, returns normal or slow
// - reset exits standby, initialises all state
module smc_standby_ctrl
  import smc_pkg::*;
#(
  parameter int PRIO_WIDTH = PRIO_W,
  parameter int NPERIPH = PERIPH_N
) (
  input wire logic mclk,
  input wire logic rst_n,
  // core requests
  input wire logic haltRequest,
  input wire logic dozeRequest,
  input wire logic requestWriteDone,
  input wire logic [1:0] standby_select,
  input wire logic [15:0] processorStatus,
  input wire logic slowActive,
  input wire logic externalClock,
  // return configuration
  input wire logic return_high_osc_enable,
  input wire logic return_low_osc_enable,
  input wire logic return_clock_select,
  input wire logic [1:0] warmup_time_select,
  input wire logic [NPERIPH-1:0] periphIdleEnable,
  // interrupt controller
  input wire logic irqValid,
  input wire logic [PRIO_WIDTH-1:0] irqPriority,
  input wire logic irqRtcWake,
  input wire logic irqExtPinWake,
  input wire logic irqWatchdogWake,
  input wire logic irqDmaWake,
  input wire logic nmiRequest,
  input wire logic busRequest,
  // clock gates and status
  output logic highOscEnable,
  output logic lowOscEnable,
  output logic pllEnable,
  output logic cpuClockEnable,
  output logic coreFreeze,
  output logic dmaClockEnable,
  output logic ioPortClockEnable,
  output logic irqCtrlClockEnable,
  output logic busIfClockEnable,
  output logic rtcClockEnable,
  output logic [NPERIPH-1:0] periphClockEnable,
  output logic busGrant,
  output logic wakeService,
  output logic wakeRetry,
  output logic returnSlow,
  output logic [2:0] modeStatus
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  smc_state_t state;
  smc_state_t next_state;
  logic [2:0] mask;
  logic wake;
  logic wakeIrq;
  logic unmasked;
  logic eligible;
  logic lsRun;
  logic lsTick;
  logic wupStart;
  logic wupDone;
  logic pendService;
  logic armDoze;

  assign mask = processorStatus[MASK_MSB:MASK_LSB];

  // ----------------------------------------------------------------
  // state decoding shared by the resume decision and the gates
  // ----------------------------------------------------------------
  // modes that wait for a wake-up
  function automatic logic in_standby(input smc_state_t s);
    in_standby = (s inside {SM_HALT, SM_DOZE, SM_SLEEP, SM_STOP});
  endfunction : in_standby

  // the two idle forms; the core is frozen, not reset
  function automatic logic in_idle(input smc_state_t s);
    in_idle = (s inside {SM_HALT, SM_DOZE});
  endfunction : in_idle

  // modes in which the cpu clock runs
  function automatic logic cpu_runs(input smc_state_t s);
    cpu_runs = (s inside {SM_NORMAL, SM_SLOW, SM_ARM});
  endfunction : cpu_runs

  // modes with the high-speed domain unclocked
  function automatic logic fabric_off(input smc_state_t s);
    fabric_off = (s inside {SM_SLEEP, SM_STOP, SM_WARMUP});
  endfunction : fabric_off

  // ----------------------------------------------------------------
  // wake qualification
  // ----------------------------------------------------------------
  // which sources may wake depends on mode
  always_comb begin
    eligible = 1'b0;
    unique case (state)
      // dma requests only wake the doze form, since halt stops the dma
      SM_HALT: eligible = irqValid && !irqDmaWake;
      SM_DOZE: eligible = irqValid;
      SM_SLEEP: eligible = irqValid && (irqRtcWake || irqExtPinWake || irqWatchdogWake);
      SM_STOP: eligible = irqValid && irqExtPinWake;
      SM_NORMAL, SM_SLOW, SM_WARMUP, SM_ARM: eligible = 1'b0;
    endcase
  end

  assign unmasked = irqPriority > PRIO_WIDTH'(mask);
  // masked sources still wake but resume as retry
  assign wakeIrq = eligible;
  assign wake = wakeIrq || nmiRequest;

  // ----------------------------------------------------------------
  // low-speed tick and warm-up timer
  // ----------------------------------------------------------------
  // tick stops in stop mode, but resumes once the oscillator restarts
  assign lsRun = (state != SM_STOP);

  smc_tick_div u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(lsRun),
    .tick(lsTick)
  );

  // warm-up starts on the wake itself, not a cycle later
  assign wupStart = (state == SM_STOP) && wake;

  smc_warmup u_wup (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(wupStart),
    .tick(lsTick),
    .warmup_time_select(warmup_time_select),
    .done(wupDone)
  );

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      // requests are ignored in every other mode
      SM_NORMAL, SM_SLOW: begin
        if (dozeRequest || haltRequest) begin
          next_state = SM_ARM;
        end
      end
      SM_ARM: begin
        // gate only once the requesting write has retired
        if (requestWriteDone) begin
          if (armDoze) begin
            next_state = SM_DOZE;
          end else begin
            unique case (standby_select)
              SEL_STOP: next_state = SM_STOP;
              SEL_SLEEP: next_state = SM_SLEEP;
              default: next_state = SM_HALT;
            endcase
          end
        end
      end
      SM_HALT, SM_DOZE, SM_SLEEP: begin
        if (wake) begin
          next_state = return_clock_select ? SM_SLOW : SM_NORMAL;
        end
      end
      SM_STOP: begin
        if (wake) begin
          next_state = SM_WARMUP;
        end
      end
      SM_WARMUP: begin
        if (wupDone) begin
          next_state = return_clock_select ? SM_SLOW : SM_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= SM_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // request capture; doze takes precedence over halt
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      armDoze <= 1'b0;
    end else if ((state == SM_NORMAL) || (state == SM_SLOW)) begin
      armDoze <= dozeRequest;
    end
  end

  // ----------------------------------------------------------------
  // resume decision
  // ----------------------------------------------------------------
  // decision is latched at the wake so it survives the stop warm-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pendService <= 1'b0;
      returnSlow <= 1'b0;
    end else if (wake && in_standby(state)) begin
      pendService <= nmiRequest || unmasked;
      returnSlow <= return_clock_select;
    end
  end

  // one-cycle pulses: idle and sleep answer at once, stop only after warm-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wakeService <= 1'b0;
      wakeRetry <= 1'b0;
    end else if (wake && in_standby(state) && (state != SM_STOP)) begin
      wakeService <= nmiRequest || unmasked;
      wakeRetry <= !(nmiRequest || unmasked);
    end else if ((state == SM_WARMUP) && wupDone) begin
      wakeService <= pendService;
      wakeRetry <= !pendService;
    end else begin
      wakeService <= 1'b0;
      wakeRetry <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock gating per mode
  // ----------------------------------------------------------------
  // one gate per peripheral, each from its own idle enable
  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++) begin : g_pclk
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          periphClockEnable[gi] <= 1'b1;
        end else begin
          unique case (next_state)
            SM_NORMAL, SM_ARM: periphClockEnable[gi] <= 1'b1;
            SM_SLOW: periphClockEnable[gi] <= (gi == PG_WDOG);
            SM_HALT, SM_DOZE: periphClockEnable[gi] <= periphIdleEnable[gi];
            SM_SLEEP, SM_STOP, SM_WARMUP: periphClockEnable[gi] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // an external clock leaves the on-chip oscillator off
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      highOscEnable <= 1'b1;
      lowOscEnable <= 1'b1;
      pllEnable <= 1'b1;
    end else begin
      highOscEnable <= !externalClock && !(next_state inside {SM_SLEEP, SM_STOP});
      lowOscEnable <= (next_state != SM_STOP);
      pllEnable <= (next_state inside {SM_NORMAL, SM_ARM, SM_HALT, SM_DOZE}) && !slowActive;
    end
  end

  // the freeze only stops the core, its pipeline contents stay put
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpuClockEnable <= 1'b1;
      coreFreeze <= 1'b0;
    end else begin
      cpuClockEnable <= cpu_runs(next_state);
      coreFreeze <= in_idle(next_state);
    end
  end

  // dma, ports, interrupt controller and bus interface follow the mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dmaClockEnable <= 1'b1;
      ioPortClockEnable <= 1'b1;
      irqCtrlClockEnable <= 1'b1;
      busIfClockEnable <= 1'b1;
    end else begin
      dmaClockEnable <= (next_state inside {SM_NORMAL, SM_ARM, SM_DOZE});
      ioPortClockEnable <= (next_state inside {SM_NORMAL, SM_SLOW, SM_ARM, SM_DOZE});
      irqCtrlClockEnable <= !fabric_off(next_state);
      busIfClockEnable <= !fabric_off(next_state);
    end
  end

  // rtc runs from the low-speed clock in every mode but stop and its warm-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rtcClockEnable <= 1'b1;
    end else begin
      rtcClockEnable <= (next_state != SM_STOP) && (next_state != SM_WARMUP);
    end
  end

  // status is taken from next_state too, so it never lags the gates
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      modeStatus <= 3'h0;
    end else begin
      modeStatus <= next_state;
    end
  end

  // halt keeps mastership; doze, normal and slow grant requests
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busGrant <= 1'b0;
    end else begin
      busGrant <= busRequest && (next_state inside {SM_NORMAL, SM_SLOW, SM_DOZE});
    end
  end

endmodule : smc_standby_ctrl

// ### bench/smc_standby_ctrl_sva.sv
`timescale 1ns/100ps
module smc_standby_sva
  import smc_pkg::*;
#(
  parameter int NPERIPH = PERIPH_N
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic haltRequest,
  input wire logic requestWriteDone,
  input wire logic [NPERIPH-1:0] periphIdleEnable,
  input wire logic nmiRequest,
  input wire logic busRequest,
  input wire logic highOscEnable,
  input wire logic lowOscEnable,
  input wire logic pllEnable,
  input wire logic cpuClockEnable,
  input wire logic coreFreeze,
  input wire logic rtcClockEnable,
  input wire logic [NPERIPH-1:0] periphClockEnable,
  input wire logic busGrant,
  input wire logic wakeService,
  input wire logic wakeRetry,
  input wire logic [2:0] modeStatus
);
  // ----------------------------------------------------------------
  // mode and gating checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire logic [4:0] gates = {highOscEnable, lowOscEnable, pllEnable, cpuClockEnable, rtcClockEnable};
  entry_arm_a: assert property (modeStatus == SM_NORMAL && haltRequest |=> modeStatus == SM_ARM)
    else $error("halt request not taken");
  arm_hold_a: assert property (modeStatus == SM_ARM && !requestWriteDone |=> modeStatus == SM_ARM)
    else $error("standby entered before write done");
  halt_freeze_a: assert property (modeStatus == SM_HALT |-> coreFreeze && !cpuClockEnable && !busGrant)
    else $error("halt idle not frozen");
  doze_grant_a: assert property (modeStatus == SM_DOZE && busRequest ##1 modeStatus == SM_DOZE |-> busGrant)
    else $error("doze idle bus not granted");
  // idle enables are copied through; a change mid-idle is allowed one cycle to land
  idle_periph_a: assert property (modeStatus inside {SM_HALT, SM_DOZE} && $stable(periphIdleEnable)
    |-> periphClockEnable == periphIdleEnable)
    else $error("idle peripheral gate wrong");
  sleep_gate_a: assert property (modeStatus == SM_SLEEP |-> gates == 5'h09 && periphClockEnable == '0)
    else $error("sleep clock gates wrong");
  stop_gate_a: assert property (modeStatus == SM_STOP |-> gates == 5'h00 && periphClockEnable == '0)
    else $error("stop clock gates wrong");
  stop_warm_a: assert property (modeStatus == SM_STOP ##1 modeStatus != SM_STOP |-> modeStatus == SM_WARMUP)
    else $error("stop left without warm-up");
  nmi_wake_a: assert property (modeStatus inside {SM_HALT, SM_DOZE, SM_SLEEP} && nmiRequest |=> wakeService)
    else $error("nmi wake not serviced");
  cover property (modeStatus == SM_WARMUP);
  cover property (wakeRetry);
  cover property (busGrant);
endmodule : smc_standby_sva

bind smc_standby_ctrl smc_standby_sva #(.NPERIPH(NPERIPH)) u_sva (.mclk, .rst_n, .haltRequest,
  .requestWriteDone, .periphIdleEnable, .nmiRequest, .busRequest, .highOscEnable, .lowOscEnable,
  .pllEnable, .cpuClockEnable, .coreFreeze, .rtcClockEnable, .periphClockEnable, .busGrant,
  .wakeService, .wakeRetry, .modeStatus);

// ### bench/smc_core_model.sv
`timescale 1ns/100ps
module smc_core_model
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire logic doze,
  input wire logic [3:0] lat,
  input wire logic [2:0] modeStatus,
  output logic haltRequest = 1'b0,
  output logic dozeRequest = 1'b0,
  output logic requestWriteDone = 1'b0
);
  // ----------------------------------------------------------------
  // core: request bit, then the write retires after lat cycles
  // ----------------------------------------------------------------
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge mclk) begin
    requestWriteDone <= 1'b0;
    if (go) begin
      haltRequest <= !doze;
      dozeRequest <= doze;
      cnt <= lat;
    end else if (modeStatus == SM_ARM) begin
      if (cnt == 4'h0) begin
        requestWriteDone <= 1'b1;
        haltRequest <= 1'b0;
        dozeRequest <= 1'b0;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : smc_core_model

// ### bench/tb.sv
`timescale 1ns/100ps
module tb
  import smc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n, go, doze, requestWriteDone, haltRequest, dozeRequest, slowActive, externalClock;
  logic return_high_osc_enable, return_low_osc_enable, return_clock_select, irqValid, nmiRequest;
  logic irqRtcWake, irqExtPinWake, irqWatchdogWake, irqDmaWake, busRequest, busGrant, returnSlow;
  logic highOscEnable, lowOscEnable, pllEnable, cpuClockEnable, coreFreeze, dmaClockEnable;
  logic ioPortClockEnable, irqCtrlClockEnable, busIfClockEnable, rtcClockEnable, wakeService, wakeRetry;
  logic [1:0] standby_select, warmup_time_select;
  logic [2:0] irqPriority, modeStatus;
  logic [3:0] lat;
  logic [4:0] periphIdleEnable, periphClockEnable;
  logic [15:0] processorStatus;
  int errorCnt = 0;
  int checks = 0;
  int n, i;
  wire logic [4:0] clkGates = {highOscEnable, lowOscEnable, pllEnable, cpuClockEnable, rtcClockEnable};
  wire logic [4:0] idleGates = {coreFreeze, dmaClockEnable, ioPortClockEnable, irqCtrlClockEnable, busIfClockEnable};
  logic [2:0] modeTab[4] = '{3'h2, 3'h5, 3'h4, 3'h2};
  logic [4:0] clkTab[4] = '{5'h1D, 5'h00, 5'h09, 5'h1D};
  logic [3:0] clsTab[4] = '{4'h2, 4'h4, 4'h8, 4'h0};

  always #12.5 mclk = ~mclk;

  smc_standby_ctrl u_dut (.mclk, .rst_n, .haltRequest, .dozeRequest, .requestWriteDone, .standby_select,
    .processorStatus, .slowActive, .externalClock, .return_high_osc_enable, .return_low_osc_enable,
    .return_clock_select, .warmup_time_select, .periphIdleEnable, .irqValid, .irqPriority, .irqRtcWake,
    .irqExtPinWake, .irqWatchdogWake, .irqDmaWake, .nmiRequest, .busRequest, .highOscEnable, .lowOscEnable,
    .pllEnable, .cpuClockEnable, .coreFreeze, .dmaClockEnable, .ioPortClockEnable, .irqCtrlClockEnable,
    .busIfClockEnable, .rtcClockEnable, .periphClockEnable, .busGrant, .wakeService, .wakeRetry,
    .returnSlow, .modeStatus);
  smc_core_model u_core (.mclk, .go, .doze, .lat, .modeStatus, .haltRequest, .dozeRequest, .requestWriteDone);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic enter(input logic dz, input logic [1:0] s, input logic [3:0] l);
    doze = dz;
    standby_select = s;
    lat = l;
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    for (n = 0; n < 40 && modeStatus inside {3'h0, 3'h1, 3'h7}; n++) @(negedge mclk);
  endtask : enter

  // only the chosen wake source is raised, the rest stay quiet
  task automatic wake(input logic [2:0] p, input logic [3:0] c, input logic m, input logic [2:0] md,
    input logic sv);
    irqValid = !m;
    irqPriority = p;
    {irqRtcWake, irqExtPinWake, irqWatchdogWake, irqDmaWake} = c;
    nmiRequest = m;
    for (n = 0; n < 5000 && modeStatus inside {[3'h2:3'h6]}; n++) @(negedge mclk);
    chk("mode", modeStatus, md);
    chk("service", wakeService, sv);
    chk("retry", wakeRetry, !sv);
    irqValid = 1'b0;
    {irqRtcWake, irqExtPinWake, irqWatchdogWake, irqDmaWake, nmiRequest} = 5'h00;
    @(negedge mclk);
  endtask : wake

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n, go, doze, slowActive, externalClock, return_high_osc_enable, return_low_osc_enable} = 7'h00;
    {return_clock_select, irqValid, nmiRequest, busRequest, irqPriority, lat} = 11'h000;
    {irqRtcWake, irqExtPinWake, irqWatchdogWake, irqDmaWake} = 4'h0;
    {standby_select, warmup_time_select, processorStatus} = 20'h00000;
    periphIdleEnable = 5'h0A;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk("mode", modeStatus, 3'h0);
    chk("clocks", clkGates, 5'h1F);
    externalClock = 1'b1;
    repeat (2) @(negedge mclk);
    chk("ext clocks", clkGates, 5'h0F);
    externalClock = 1'b0;
    for (i = 0; i < 4; i++) begin
      enter(1'b0, i[1:0], i[3:0]);
      chk("mode", modeStatus, modeTab[i]);
      chk("clocks", clkGates, clkTab[i]);
      wake(3'h7, clsTab[i], i == 3, 3'h0, 1'b1);
    end
    busRequest = 1'b1;
    enter(1'b0, 2'h3, 4'h0);
    chk("idle gates", idleGates, 5'h13);
    chk("periph", periphClockEnable, 5'h0A);
    chk("grant", busGrant, 1'b0);
    {irqValid, irqDmaWake, irqPriority} = 5'h1F;
    repeat (3) @(negedge mclk);
    chk("mode", modeStatus, 3'h2);
    {irqValid, irqDmaWake} = 2'h0;
    processorStatus = 16'h4000;
    wake(3'h5, 4'h2, 1'b0, 3'h0, 1'b1);
    enter(1'b1, 2'h1, 4'h2);
    chk("mode", modeStatus, 3'h3);
    chk("idle gates", idleGates, 5'h1F);
    chk("grant", busGrant, 1'b1);
    processorStatus = 16'h8000;
    wake(3'h4, 4'h1, 1'b0, 3'h0, 1'b0);
    busRequest = 1'b0;
    return_clock_select = 1'b1;
    enter(1'b0, 2'h1, 4'h1);
    wake(3'h0, 4'h0, 1'b1, 3'h1, 1'b1);
    chk("slow", returnSlow, 1'b1);
    chk("slow clocks", clkGates, 5'h1B);
    chk("slow gates", idleGates, 5'h07);
    chk("slow periph", periphClockEnable, 5'h10);
    enter(1'b0, 2'h2, 4'h0);
    chk("mode", modeStatus, 3'h4);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk("mode", modeStatus, 3'h0);
    chk("clocks", clkGates, 5'h1F);
    summarize();
  end

  // two stop wakes of about 1220 cycles each dominate the run
  initial begin
    repeat (40000) @(posedge mclk);
    errorCnt++;
    summarize();
  end
endmodule : tb
